// *** hdl/tpc_top.v ***
// period and pulse-width capture timer with a classic Wishbone register slave
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_consts.vh"

module tpc_top #(
  parameter CNT_W = 16
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        event_i,
  input  wire        pin_i,
  output reg         irq_o
);

  reg  [`TPC_CTL_WIDTH-1:0] ctrl_reg;
  reg  [`TPC_EVT_WIDTH-1:0] irq_en_reg;
  reg                       err_reg;
  reg  [CNT_W-1:0]          count_reg;
  reg  [CNT_W-1:0]          count_next;
  reg                       run_reg;
  reg                       run_next;
  reg                       cap0;
  reg                       cap1;
  reg  [31:0]               rd_data;

  wire                      rise;
  wire                      fall;
  wire [CNT_W-1:0]          val0;
  wire [CNT_W-1:0]          val1;
  wire                      flag0;
  wire                      flag1;
  wire                      ovf0;
  wire                      ovf1;
  wire                      bus_req;
  wire                      bus_wr;
  wire                      wr_ctrl;
  wire                      wr_clear;
  wire                      wr_irq_en;
  wire [`TPC_EVT_WIDTH-1:0] clr_bits;
  wire [`TPC_EVT_WIDTH-1:0] status_bits;
  wire [1:0]                action;
  wire                      enable;

  // pads a field to a bus word
  function [31:0] tpc_word;
    input [CNT_W-1:0] v;
    begin
      tpc_word = 32'h0000_0000;
      tpc_word[CNT_W-1:0] = v;
    end
  endfunction

  assign enable  = ctrl_reg[`TPC_CTL_ENABLE];
  assign action  = ctrl_reg[`TPC_CTL_ACTION_HI:`TPC_CTL_ACTION_LO];

  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
  assign wr_ctrl   = bus_wr & (wb_adr_i == `TPC_OFS_CONTROL);
  assign wr_clear  = bus_wr & (wb_adr_i == `TPC_OFS_CLEAR);
  assign wr_irq_en = bus_wr & (wb_adr_i == `TPC_OFS_IRQ_ENABLE);
  assign clr_bits  = wr_clear ? wb_dat_i[`TPC_EVT_WIDTH-1:0] : `TPC_EVT_RESET;

  assign status_bits = {err_reg, flag1, flag0};

  tpc_edge u_edge (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .ce_i                   (ce_i),
    .src_pin_i              (ctrl_reg[`TPC_CTL_SRC_PIN]),
    .event_i                (event_i),
    .pin_i                  (pin_i),
    .event_input_invert_i   (ctrl_reg[`TPC_CTL_EV_INVERT]),
    .pin_input_invert_bit_i (ctrl_reg[`TPC_CTL_PIN_INVERT]),
    .rise_o                 (rise),
    .fall_o                 (fall)
  );

  tpc_chan #(
    .CNT_W (CNT_W)
  ) u_chan0 (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .ce_i             (ce_i),
    .capture_enable_i (ctrl_reg[`TPC_CTL_CAPT_EN0]),
    .capture_i        (cap0),
    .value_i          (count_reg),
    .clear_i          (clr_bits[`TPC_ST_FLAG0]),
    .value_o          (val0),
    .flag_o           (flag0),
    .overflow_o       (ovf0)
  );

  tpc_chan #(
    .CNT_W (CNT_W)
  ) u_chan1 (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .ce_i             (ce_i),
    .capture_enable_i (ctrl_reg[`TPC_CTL_CAPT_EN1]),
    .capture_i        (cap1),
    .value_i          (count_reg),
    .clear_i          (clr_bits[`TPC_ST_FLAG1]),
    .value_o          (val1),
    .flag_o           (flag1),
    .overflow_o       (ovf1)
  );

  // capture strobes and counter control per event action
  always @* begin
    cap0       = 1'b0;
    cap1       = 1'b0;
    run_next   = run_reg;
    count_next = run_reg ? count_reg + {{(CNT_W-1){1'b0}}, 1'b1} : count_reg;
    if (!enable) begin
      run_next   = 1'b1;
      count_next = {CNT_W{1'b0}};
    end else begin
      case (action)
        `TPC_ACT_PER_SECOND: begin
          // period to one, width to zero
          cap1 = rise;
          cap0 = fall;
          run_next = 1'b1;
          if (rise) begin
            count_next = {CNT_W{1'b0}};
          end
        end
        `TPC_ACT_PER_FIRST: begin
          // period to zero, width to one
          cap0 = rise;
          cap1 = fall;
          run_next = 1'b1;
          if (rise) begin
            count_next = {CNT_W{1'b0}};
          end
        end
        `TPC_ACT_PULSE: begin
          // capture, clear and stop on fall
          if (fall) begin
            cap0       = 1'b1;
            count_next = {CNT_W{1'b0}};
            run_next   = 1'b0;
          end else if (rise) begin
            run_next = 1'b1;
          end
        end
        default: begin
          run_next = 1'b1;
        end
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= {CNT_W{1'b0}};
      run_reg   <= 1'b1;
      err_reg   <= 1'b0;
    end else if (ce_i) begin
      count_reg <= count_next;
      run_reg   <= run_next;
      err_reg   <= ovf0 | ovf1 | (err_reg & ~clr_bits[`TPC_ST_ERR]);
    end
  end

  // register read mux
  always @* begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `TPC_OFS_CONTROL: begin
        rd_data[`TPC_CTL_WIDTH-1:0] = ctrl_reg;
      end
      `TPC_OFS_STATUS: begin
        rd_data[`TPC_EVT_WIDTH-1:0] = status_bits;
        rd_data[`TPC_ST_RUNNING]    = run_reg & enable;
      end
      `TPC_OFS_IRQ_ENABLE: begin
        rd_data[`TPC_EVT_WIDTH-1:0] = irq_en_reg;
      end
      `TPC_OFS_CAPTURE0: begin
        rd_data = tpc_word(val0);
      end
      `TPC_OFS_CAPTURE1: begin
        rd_data = tpc_word(val1);
      end
      `TPC_OFS_COUNT: begin
        rd_data = tpc_word(count_reg);
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // wishbone slave, one registered ack per request, a cycle after it
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg   <= `TPC_CTL_RESET;
      irq_en_reg <= `TPC_EVT_RESET;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
      irq_o      <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
      end
      if (wr_ctrl) begin
        ctrl_reg <= wb_dat_i[`TPC_CTL_WIDTH-1:0];
      end
      if (wr_irq_en) begin
        irq_en_reg <= wb_dat_i[`TPC_EVT_WIDTH-1:0];
      end
      irq_o <= |(status_bits & irq_en_reg);
    end
  end

endmodule

`default_nettype wire

// *** hdl/tpc_consts.vh ***
// offsets, field positions and reset values of the period and pulse capture timer
`ifndef TPC_CONSTS_VH
`define TPC_CONSTS_VH

`define TPC_OFS_CONTROL      8'h00
`define TPC_OFS_STATUS       8'h04
`define TPC_OFS_CLEAR        8'h08
`define TPC_OFS_IRQ_ENABLE   8'h0C
`define TPC_OFS_CAPTURE0     8'h10
`define TPC_OFS_CAPTURE1     8'h14
`define TPC_OFS_COUNT        8'h18

`define TPC_CTL_ENABLE       0
`define TPC_CTL_ACTION_LO    1
`define TPC_CTL_ACTION_HI    2
`define TPC_CTL_EV_INVERT    3
`define TPC_CTL_SRC_PIN      4
`define TPC_CTL_CAPT_EN0     5
`define TPC_CTL_CAPT_EN1     6
`define TPC_CTL_PIN_INVERT   7
`define TPC_CTL_WIDTH        8
`define TPC_CTL_RESET        8'h00

`define TPC_ACT_OFF          2'h0
`define TPC_ACT_PER_SECOND   2'h1
`define TPC_ACT_PER_FIRST    2'h2
`define TPC_ACT_PULSE        2'h3

`define TPC_ST_FLAG0         0
`define TPC_ST_FLAG1         1
`define TPC_ST_ERR           2
`define TPC_ST_RUNNING       3
`define TPC_EVT_WIDTH        3
`define TPC_EVT_RESET        3'h0

`endif

// *** hdl/tpc_edge.v ***
// input selection, inversion and edge detection for the capture timer
`timescale 1ns/1ps
`default_nettype none

module tpc_edge (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire src_pin_i,
  input  wire event_i,
  input  wire pin_i,
  input  wire event_input_invert_i,
  input  wire pin_input_invert_bit_i,
  output reg  rise_o,
  output reg  fall_o
);

  reg  prev_reg;
  wire level;

  assign level = (src_pin_i ? (pin_i ^ pin_input_invert_bit_i) : event_i) ^ event_input_invert_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
      rise_o   <= 1'b0;
      fall_o   <= 1'b0;
    end else if (ce_i) begin
      prev_reg <= level;
      rise_o   <= level & ~prev_reg;
      fall_o   <= ~level & prev_reg;
    end
  end

endmodule

`default_nettype wire

// *** hdl/tpc_chan.v ***
// one capture channel: stored value, capture flag and overflow detection
`timescale 1ns/1ps
`default_nettype none

module tpc_chan #(
  parameter CNT_W = 16
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  input  wire             capture_enable_i,
  input  wire             capture_i,
  input  wire [CNT_W-1:0] value_i,
  input  wire             clear_i,
  output reg  [CNT_W-1:0] value_o,
  output reg              flag_o,
  output wire             overflow_o
);

  wire take;

  assign take       = capture_i & capture_enable_i;
  // capture over set flag is error
  assign overflow_o = take & flag_o;

  always @(posedge clk_i) begin
    if (rst_i) begin
      value_o <= {CNT_W{1'b0}};
      flag_o  <= 1'b0;
    end else if (ce_i) begin
      if (take && !flag_o) begin
        value_o <= value_i;
      end
      // flag on valid capture, set wins
      flag_o <= take | (flag_o & ~clear_i);
    end
  end

endmodule

`default_nettype wire

// *** test/tpc_top_sva.sv ***
// port checker for the capture timer, with its bind
`timescale 1ns/1ps
`default_nettype none
module tpc_top_sva #(
  parameter CNT_W = 16
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire        req = wb_cyc_i & wb_stb_i & ce_i;
  wire        wr  = req & wb_we_i;
  logic [3:0] w_cnt;
  logic       wrote;
  // cycles since the last register write, saturating
  always @(posedge clk_i) begin
    if (rst_i) begin
      w_cnt <= 4'h0;
      wrote <= 1'b0;
    end else begin
      w_cnt <= wr ? 4'h0 : w_cnt + {3'h0, w_cnt != 4'hF};
      wrote <= wrote | wr;
    end
  end
  sequence s_req; req && !wb_ack_o; endsequence
  sequence s_ack; ##1 wb_ack_o; endsequence
  a_ack_one_late: assert property (s_req |-> s_ack) else $error("ack late");
  a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
  a_write_dat_zero: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0) else $error("write data");
  a_read_width: assert property (wb_ack_o |-> (wb_dat_o >> CNT_W) == 32'h0) else $error("read width");
  a_irq_needs_en: assert property (irq_o |-> wrote) else $error("irq unenabled");
  a_irq_sticky_flag: assert property (irq_o && !wr && !$past(wr) |=> irq_o) else $error("irq dropped");
  a_irq_fall_cause: assert property ($fell(irq_o) |-> w_cnt <= 4'h3) else $error("irq fell");
endmodule
bind tpc_top tpc_top_sva #(.CNT_W(CNT_W)) i_sva (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire

// *** test/tpc_sig_src.sv ***
// input source: chosen line carries the pulse train, the other toggles
`timescale 1ns/1ps
`default_nettype none
module tpc_sig_src (
  input  wire logic       clk_i,
  input  wire logic       to_pin_i,
  input  wire logic [7:0] hi_i,
  input  wire logic [7:0] lo_i,
  output var  logic       event_o,
  output var  logic       pin_o
);
  logic [7:0] cnt  = 8'h0;
  logic       lvl  = 1'b0;
  logic       junk = 1'b0;
  always @(posedge clk_i) begin
    junk <= ~junk;
    if (cnt + 8'h1 >= (lvl ? hi_i : lo_i)) begin
      cnt <= 8'h0;
      lvl <= ~lvl;
    end else begin
      cnt <= cnt + 8'h1;
    end
  end
  assign event_o = to_pin_i ? junk : lvl;
  assign pin_o   = to_pin_i ? lvl : junk;
endmodule
`default_nettype wire

// *** test/tpc_top_bench.sv ***
// self-checking bench for the capture timer
`timescale 1ns/1ps
`default_nettype none
`include "tpc_consts.vh"
module tpc_top_bench;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        cyc    = 1'b0;
  logic        we     = 1'b0;
  logic [7:0]  adr    = 8'h0;
  logic [31:0] wdat   = 32'h0;
  logic [31:0] rdat;
  logic        to_pin = 1'b0;
  logic [7:0]  hi     = 8'h4;
  logic [7:0]  lo     = 8'h4;
  wire  [31:0] dat_o;
  wire         ack, irq, ev, pin;
  int          err_count = 0;
  int          total_checks = 0;
  int          m0 = 0;
  int          m1 = 0;
  logic [7:0]  cfgs [7] = '{8'h63, 8'h6D, 8'hB5, 8'h61, 8'hDB, 8'hB7, 8'h67};
  always #5 clk_i = ~clk_i;
  tpc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .event_i(ev),
    .pin_i(pin), .irq_o(irq));
  tpc_sig_src i_src (.clk_i(clk_i), .to_pin_i(to_pin), .hi_i(hi), .lo_i(lo), .event_o(ev), .pin_o(pin));
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) err_count++;
    rdat = dat_o;
    cyc <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
  initial begin
    int seed, act, inv, per, wid, f0, f1;
    logic [7:0] c;
    seed = $urandom(32'hFB99);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `TPC_OFS_CONTROL, 0);
    chk("control", rdat, {24'h0, `TPC_CTL_RESET});
    wb(0, 8'h3C, 0);
    chk("unmapped", rdat, 32'h0);
    wb(1, `TPC_OFS_IRQ_ENABLE, 32'h7);
    foreach (cfgs[i]) begin
      c = cfgs[i];
      wb(1, `TPC_OFS_CONTROL, 32'h0);
      hi <= 8'(3 + $urandom % 12);
      lo <= 8'(3 + $urandom % 12);
      to_pin <= c[`TPC_CTL_SRC_PIN];
      wb(1, `TPC_OFS_CONTROL, {24'h0, c});
      repeat (2 * (hi + lo) + 4) @(posedge clk_i);
      wb(1, `TPC_OFS_CLEAR, 32'h7);
      repeat (3 * (hi + lo) + 8) @(posedge clk_i);
      act = c[`TPC_CTL_ACTION_HI:`TPC_CTL_ACTION_LO];
      inv = c[`TPC_CTL_EV_INVERT] ^ (c[`TPC_CTL_SRC_PIN] & c[`TPC_CTL_PIN_INVERT]);
      per = hi + lo - 1;
      wid = (inv ? lo : hi) - 1;
      f0 = c[`TPC_CTL_CAPT_EN0] && act != 0;
      f1 = c[`TPC_CTL_CAPT_EN1] && (act == 1 || act == 2);
      if (f0) m0 = (act == 2) ? per : wid;
      if (f1) m1 = (act == 1) ? per : wid;
      wb(0, `TPC_OFS_STATUS, 0);
      chk("status", rdat & 32'h7, f0 | f1 << 1 | (f0 | f1) << 2);
      chk("irq", {31'h0, irq}, {31'h0, f0 | f1});
      wb(0, `TPC_OFS_CAPTURE0, 0);
      chk("capture0", rdat, m0);
      wb(0, `TPC_OFS_CAPTURE1, 0);
      chk("capture1", rdat, m1);
      hi <= hi + 8'h3;
      wb(1, `TPC_OFS_CAPTURE0, $urandom);
      repeat (2 * (hi + lo) + 4) @(posedge clk_i);
      wb(0, `TPC_OFS_CAPTURE0, 0);
      chk("kept0", rdat, m0);
    end
    wb(1, `TPC_OFS_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wb(1, `TPC_OFS_IRQ_ENABLE, 32'h7);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1, `TPC_OFS_CONTROL, 32'h0);
    wb(1, `TPC_OFS_CLEAR, 32'h7);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
